// *** hdl/rlvds_serializer.sv ***
`timescale 1ns/100ps
module rlvds_serializer
   import rlvds_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic pixel_clk_i,
   input wire logic capture_edge_select_i,
   input wire logic power_down_clear_n_i,
   input wire logic three_lane_mode_i,
   input wire logic [WORD_W-1:0] parallel_bits_i,
   output logic [LANES-1:0] lane_p_o,
   output logic [LANES-1:0] lane_n_o,
   output logic [LANES-1:0] lane_oe_o,
   output logic fwd_lane_clk_p_o,
   output logic fwd_lane_clk_n_o,
   output logic fwd_lane_clk_oe_o
);
   // ----------------------------------------
   // lane mapping
   // ----------------------------------------
   function automatic logic [SLICE_W-1:0] lane_slice(input logic [WORD_W-1:0] w,
                                                     input int unsigned lane);
      logic [SLICE_W-1:0] s;
      s = '0;
      unique case (lane)
         0: s = {w[GREEN_POS], w[RED_POS+5 -: 6]};
         1: s = {w[BLUE_POS+1], w[BLUE_POS], w[GREEN_POS+5 -: 5]};
         2: s = {w[PIXEL_VALID_POS], w[FRAME_SYNC_POS], w[LINE_SYNC_POS],
                 w[BLUE_POS+5 -: 4]};
         default: s = {w[SPARE_POS], w[BLUE_POS+7], w[BLUE_POS+6], w[GREEN_POS+7],
                       w[GREEN_POS+6], w[RED_POS+7], w[RED_POS+6]};
      endcase
      return s;
   endfunction

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rst_sh_q;
   logic [1:0] rst_sh_d;
   logic rst_core_n;

   always_comb begin
      rst_sh_d = {rst_sh_q[0], 1'b1};
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sh_q <= 2'h0;
      end else begin
         rst_sh_q <= rst_sh_d;
      end
   end

   assign rst_core_n = rst_sh_q[1];

   // ----------------------------------------
   // pixel side capture
   // ----------------------------------------
   logic pix_cap_clk;
   logic pix_rst_n;
   logic pix_arst_n;
   logic [WORD_W-1:0] pix_word_q;
   logic [WORD_W-1:0] pix_word_d;
   logic pix_tog_q;
   logic pix_tog_d;

   // select is static, so the clock mux never glitches in use
   assign pix_cap_clk = capture_edge_select_i ? pixel_clk_i : ~pixel_clk_i;
   // shutdown clears the capture registers at once, release waits two capture edges
   assign pix_arst_n = rst_n_i & power_down_clear_n_i;

   rlvds_sync #(
      .W(1)
   ) u_pix_rst (
      .clk_i(pix_cap_clk),
      .rst_n_i(pix_arst_n),
      .d_i(1'b1),
      .q_o(pix_rst_n)
   );

   always_comb begin
      pix_word_d = parallel_bits_i;
      pix_tog_d = ~pix_tog_q;
   end

   always_ff @(posedge pix_cap_clk or negedge pix_rst_n) begin
      if (!pix_rst_n) begin
         pix_word_q <= '0;
         pix_tog_q <= 1'b0;
      end else begin
         pix_word_q <= pix_word_d;
         pix_tog_q <= pix_tog_d;
      end
   end

   // ----------------------------------------
   // crossing into core domain
   // ----------------------------------------
   logic [2:0] sync_q;
   logic tog_s;
   logic pd_n_s;
   logic three_lane_s;

   rlvds_sync #(
      .W(3)
   ) u_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rst_core_n),
      .d_i({pix_tog_q, power_down_clear_n_i, three_lane_mode_i}),
      .q_o(sync_q)
   );

   assign tog_s = sync_q[2];
   assign pd_n_s = sync_q[1];
   assign three_lane_s = sync_q[0];

   // ----------------------------------------
   // bit slot generator and shifters
   // ----------------------------------------
   logic tog_prev_q, tog_prev_d;
   logic load_ev;
   logic [7:0] per_cnt_q, per_cnt_d;
   logic [7:0] period_q, period_d;
   logic [7:0] acc_q, acc_d;
   logic [8:0] acc_sum;
   logic tick;
   logic [2:0] slot_q, slot_d;
   logic [SLICE_W-1:0] shreg_q [LANES];
   logic [SLICE_W-1:0] shreg_d [LANES];
   logic [SLICE_W-1:0] clk_sh_q, clk_sh_d;
   logic seen_q, seen_d;
   logic lock_q, lock_d;
   logic [LANES-1:0] lane_p_q, lane_p_d;
   logic [LANES-1:0] lane_n_q, lane_n_d;
   logic [LANES-1:0] lane_oe_q, lane_oe_d;
   logic clk_p_q, clk_p_d;
   logic clk_n_q, clk_n_d;
   logic clk_oe_q, clk_oe_d;
   logic [LANES-1:0] bit_now;
   logic clk_now;
   logic drive;
   logic [SLICE_W-1:0] slice_v;

   // the word stays put for a whole pixel period, well past the toggle delay
   assign load_ev = tog_s ^ tog_prev_q;
   assign acc_sum = {1'b0, acc_q} + {5'h00, BIT_STEP};
   // seven evenly spread ticks per measured pixel period
   assign tick = (acc_sum >= {1'b0, period_q});

   always_comb begin
      tog_prev_d = tog_s;
      slice_v = '0;
      per_cnt_d = (per_cnt_q == CNT_MAX) ? per_cnt_q : per_cnt_q + 8'h01;
      period_d = period_q;
      acc_d = tick ? 8'(acc_sum - {1'b0, period_q}) : acc_sum[7:0];
      slot_d = slot_q;
      clk_sh_d = clk_sh_q;
      seen_d = seen_q;
      lock_d = lock_q;
      bit_now = lane_p_q;
      clk_now = clk_p_q;
      for (int k = 0; k < LANES; k++) begin
         shreg_d[k] = shreg_q[k];
      end
      if (load_ev) begin
         // every pixel period reloads all four lanes at once
         for (int k = 0; k < LANES; k++) begin
            slice_v = lane_slice(pix_word_q, k);
            bit_now[k] = slice_v[SLICE_W-1];
            shreg_d[k] = {slice_v[SLICE_W-2:0], 1'b0};
         end
         clk_now = CLK_PATTERN[SLICE_W-1];
         clk_sh_d = {CLK_PATTERN[SLICE_W-2:0], 1'b0};
         slot_d = 3'h1;
         acc_d = 8'h00;
         period_d = per_cnt_q + 8'h01;
         per_cnt_d = 8'h00;
         seen_d = 1'b1;
         lock_d = seen_q;
      end else if (tick && slot_q != SLOT_LAST) begin
         // extra ticks after the seventh bit wait for the next load
         for (int k = 0; k < LANES; k++) begin
            bit_now[k] = shreg_q[k][SLICE_W-1];
            shreg_d[k] = {shreg_q[k][SLICE_W-2:0], 1'b0};
         end
         clk_now = clk_sh_q[SLICE_W-1];
         clk_sh_d = {clk_sh_q[SLICE_W-2:0], 1'b0};
         slot_d = slot_q + 3'h1;
      end else if (per_cnt_q >= IDLE_CYCLES) begin
         // pixel clock stopped: drop lock until it runs again
         seen_d = 1'b0;
         lock_d = 1'b0;
      end
      drive = lock_d;
      for (int k = 0; k < LANES; k++) begin
         lane_oe_d[k] = drive && !(three_lane_s && k == FOURTH_LANE);
         lane_p_d[k] = lane_oe_d[k] & bit_now[k];
         lane_n_d[k] = lane_oe_d[k] & ~bit_now[k];
      end
      clk_oe_d = drive;
      clk_p_d = drive & clk_now;
      clk_n_d = drive & ~clk_now;
      if (!pd_n_s) begin
         // shutdown: everything idles and clears, drivers off
         tog_prev_d = tog_s;
         per_cnt_d = 8'h00;
         period_d = 8'h00;
         acc_d = 8'h00;
         slot_d = 3'h0;
         clk_sh_d = '0;
         seen_d = 1'b0;
         lock_d = 1'b0;
         for (int k = 0; k < LANES; k++) begin
            shreg_d[k] = '0;
         end
         lane_oe_d = '0;
         lane_p_d = '0;
         lane_n_d = '0;
         clk_oe_d = 1'b0;
         clk_p_d = 1'b0;
         clk_n_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_core_n) begin
      if (!rst_core_n) begin
         tog_prev_q <= 1'b0;
         per_cnt_q <= 8'h00;
         period_q <= 8'h00;
         acc_q <= 8'h00;
         slot_q <= 3'h0;
         clk_sh_q <= '0;
         seen_q <= 1'b0;
         lock_q <= 1'b0;
         for (int k = 0; k < LANES; k++) begin
            shreg_q[k] <= '0;
         end
         lane_p_q <= '0;
         lane_n_q <= '0;
         lane_oe_q <= '0;
         clk_p_q <= 1'b0;
         clk_n_q <= 1'b0;
         clk_oe_q <= 1'b0;
      end else begin
         tog_prev_q <= tog_prev_d;
         per_cnt_q <= per_cnt_d;
         period_q <= period_d;
         acc_q <= acc_d;
         slot_q <= slot_d;
         clk_sh_q <= clk_sh_d;
         seen_q <= seen_d;
         lock_q <= lock_d;
         for (int k = 0; k < LANES; k++) begin
            shreg_q[k] <= shreg_d[k];
         end
         lane_p_q <= lane_p_d;
         lane_n_q <= lane_n_d;
         lane_oe_q <= lane_oe_d;
         clk_p_q <= clk_p_d;
         clk_n_q <= clk_n_d;
         clk_oe_q <= clk_oe_d;
      end
   end

   assign lane_p_o = lane_p_q;
   assign lane_n_o = lane_n_q;
   assign lane_oe_o = lane_oe_q;
   assign fwd_lane_clk_p_o = clk_p_q;
   assign fwd_lane_clk_n_o = clk_n_q;
   assign fwd_lane_clk_oe_o = clk_oe_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [SLICE_W-1:0] exp_lane0;
   assign exp_lane0 = lane_slice(pix_word_q, 0);

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_core_n);

   sequence s_load;
      load_ev && pd_n_s;
   endsequence

   sequence s_shutdown;
      !pd_n_s;
   endsequence

   property p_load_slot;
      s_load |=> (slot_q == 3'h1);
   endproperty
   a_load_slot: assert property (p_load_slot) else $error("load did not start slot one");

   property p_load_word;
      s_load ##1 lane_oe_q[0] |-> lane_p_q[0] == $past(exp_lane0[SLICE_W-1]);
   endproperty
   a_load_word: assert property (p_load_word) else $error("lane0 first bit wrong");

   property p_pd_clear;
      s_shutdown |=> (slot_q == 3'h0 && shreg_q[0] == '0 && shreg_q[3] == '0 && !lock_q);
   endproperty
   a_pd_clear: assert property (p_pd_clear) else $error("shutdown left state");

   property p_pd_off;
      s_shutdown |=> (lane_oe_o == '0 && !fwd_lane_clk_oe_o && lane_p_o == '0);
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("drivers on in shutdown");

   property p_slot_range;
      (slot_q == SLOT_LAST) |=> (slot_q == SLOT_LAST) || (slot_q == 3'h1) || (slot_q == 3'h0);
   endproperty
   a_slot_range: assert property (p_slot_range) else $error("more than seven bits");

   property p_clk_first;
      (s_load ##1 fwd_lane_clk_oe_o) |-> fwd_lane_clk_p_o;
   endproperty
   a_clk_first: assert property (p_clk_first) else $error("clock pattern not aligned");

   property p_three_lane;
      three_lane_s |=> !lane_oe_o[FOURTH_LANE];
   endproperty
   a_three_lane: assert property (p_three_lane) else $error("fourth lane on");

   property p_diff;
      lane_oe_o[0] |-> (lane_n_o[0] == !lane_p_o[0]) && (lane_oe_o[1] == lane_oe_o[2]);
   endproperty
   a_diff: assert property (p_diff) else $error("lane pair not complementary");
endmodule

// *** hdl/rlvds_pkg.sv ***
package rlvds_pkg;
   // ----------------------------------------
   // word layout
   // ----------------------------------------
   localparam int unsigned WORD_W = 28;
   localparam int unsigned LANES = 4;
   localparam int unsigned SLICE_W = 7;
   localparam int unsigned RED_POS = 0;
   localparam int unsigned GREEN_POS = 8;
   localparam int unsigned BLUE_POS = 16;
   localparam int unsigned LINE_SYNC_POS = 24;
   localparam int unsigned FRAME_SYNC_POS = 25;
   localparam int unsigned PIXEL_VALID_POS = 26;
   localparam int unsigned SPARE_POS = 27;
   localparam int unsigned FOURTH_LANE = 3;
   // forwarded clock shape, first transmitted bit in bit 6
   localparam logic [6:0] CLK_PATTERN = 7'h63;
   localparam logic [2:0] SLOT_LAST = 3'h7;
   localparam logic [3:0] BIT_STEP = 4'h7;
   // ----------------------------------------
   // rates and timing
   // ----------------------------------------
   localparam int unsigned CORE_PERIOD_PS = 5000;
   localparam int unsigned PIX_MIN_MHZ = 10;
   localparam int unsigned PIX_MAX_STD_MHZ = 85;
   localparam int unsigned PIX_MAX_FAST_MHZ = 135;
   localparam int unsigned IDLE_TIMEOUT_NS = 1000;
   localparam logic [7:0] IDLE_CYCLES = 8'(IDLE_TIMEOUT_NS * 1000 / CORE_PERIOD_PS);
   localparam logic [7:0] CNT_MAX = 8'hFF;
endpackage

// *** hdl/rlvds_sync.sv ***
`timescale 1ns/100ps
module rlvds_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = d_i;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_o = sync_q;
endmodule

// *** sim/rlvds_rx_model.sv ***
`timescale 1ns/100ps
module rlvds_rx_model
   import rlvds_pkg::*;
#(
   parameter int PIX_CYC = 32
) (
   input wire logic core_clk_i,
   input wire logic [LANES-1:0] lane_p_i,
   input wire logic [LANES-1:0] lane_n_i,
   input wire logic [LANES-1:0] lane_oe_i,
   input wire logic clk_p_i,
   input wire logic clk_n_i,
   input wire logic clk_oe_i,
   output logic [WORD_W-1:0] word_o = '0,
   output logic [6:0] clk_bits_o = '0,
   output int word_cnt_o = 0,
   output int period_o = 0,
   output logic pair_err_o = 1'b0
);
   logic [LANES:0] hist [0:31];
   logic [6:0] sl [0:LANES];
   logic prev_q = 1'b0;
   int age = 0;
   int since = 0;
   int idx;
   // ------------------------------
   // framing on the clock fall, which marks the third bit
   // ------------------------------
   always @(posedge core_clk_i) begin
      for (int i = 31; i > 0; i--) begin
         hist[i] <= hist[i-1];
      end
      hist[0] <= {clk_p_i, lane_p_i};
      prev_q <= clk_p_i;
      since <= since + 1;
      if ((((lane_n_i ^ ~lane_p_i) & lane_oe_i) | ((lane_p_i | lane_n_i) & ~lane_oe_i)) != '0) begin
         pair_err_o <= 1'b1;
      end
      if ((clk_oe_i && (clk_n_i === clk_p_i)) || (!clk_oe_i && (clk_p_i || clk_n_i))) begin
         pair_err_o <= 1'b1;
      end
      if (clk_oe_i && prev_q && !clk_p_i) begin
         period_o <= since;
         since <= 1;
         age <= 1;
      end else if (age != 0) begin
         age <= age + 1;
      end
      // sample each bit two cycles past its nominal start
      if (age == 21) begin
         for (int k = 0; k < 7; k++) begin
            idx = 18 - ((k - 2) * PIX_CYC) / 7;
            for (int l = 0; l <= LANES; l++) begin
               sl[l][6-k] = hist[idx][l];
            end
         end
         word_o <= {sl[3][6], sl[2][6:4], sl[3][5:4], sl[2][3:0], sl[1][6:5], sl[3][3:2],
                    sl[1][4:0], sl[0][6], sl[3][1:0], sl[0][5:0]};
         clk_bits_o <= sl[LANES];
         word_cnt_o <= word_cnt_o + 1;
      end
   end
endmodule

// *** sim/rgb_to_lvds_serializer_bench.sv ***
`timescale 1ns/100ps
module rgb_to_lvds_serializer_bench
   import rlvds_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pix_clk = 1'b0;
   logic pix_run = 1'b1;
   logic sel = 1'b0;
   logic pdn_n = 1'b1;
   logic three = 1'b0;
   logic [WORD_W-1:0] bits = '0;
   logic [WORD_W-1:0] pix_word = '0;
   logic [LANES-1:0] lane_p, lane_n, lane_oe;
   logic fclk_p, fclk_n, fclk_oe;
   logic [WORD_W-1:0] rx_word;
   logic [6:0] rx_clk;
   int rx_cnt, rx_per;
   logic rx_err;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   logic [WORD_W-1:0] pat [6] = '{28'h0000001, 28'hFFFFFFF, 28'h5A5A5A5, 28'h0C0C0C0,
                                  28'h7000000, 28'h8F0F0F0};
   wire logic [14:0] outs = {lane_p, lane_n, lane_oe, fclk_p, fclk_n, fclk_oe};
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #3.3;
      forever begin
         #80;
         if (pix_run) begin
            pix_clk = ~pix_clk;
         end
      end
   end
   // ------------------------------
   // source: word valid only around the capture edge
   // ------------------------------
   always @(pix_clk) begin
      #40;
      bits = (pix_clk == sel) ? ~pix_word : pix_word;
   end
   rlvds_serializer u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .pixel_clk_i(pix_clk),
      .capture_edge_select_i(sel), .power_down_clear_n_i(pdn_n), .three_lane_mode_i(three),
      .parallel_bits_i(bits), .lane_p_o(lane_p), .lane_n_o(lane_n), .lane_oe_o(lane_oe),
      .fwd_lane_clk_p_o(fclk_p), .fwd_lane_clk_n_o(fclk_n), .fwd_lane_clk_oe_o(fclk_oe));
   rlvds_rx_model #(.PIX_CYC(32)) u_rx (.core_clk_i(core_clk), .lane_p_i(lane_p),
      .lane_n_i(lane_n), .lane_oe_i(lane_oe), .clk_p_i(fclk_p), .clk_n_i(fclk_n),
      .clk_oe_i(fclk_oe), .word_o(rx_word), .clk_bits_o(rx_clk), .word_cnt_o(rx_cnt),
      .period_o(rx_per), .pair_err_o(rx_err));
   task automatic at(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic wait_words(input int n);
      int c0;
      c0 = rx_cnt;
      // lock after a reset or shutdown costs two pixel periods beyond the sync
      for (int i = 0; i < 100 * n + 200 && rx_cnt < c0 + n; i++) begin
         at(1);
      end
      cmp_bit(rx_cnt >= c0 + n, 1'b1);
   endtask
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_stream();
      foreach (pat[i]) begin
         pix_word = pat[i];
         wait_words(3);
         cmp_word(rx_word, pat[i]);
      end
      cmp_word(WORD_W'(rx_clk), WORD_W'(CLK_PATTERN));
      cmp_bit(rx_per >= 31 && rx_per <= 33, 1'b1);
      cmp_bit(lane_oe === 4'hF && fclk_oe === 1'b1, 1'b1);
   endtask
   task automatic t_edge(input logic s);
      pdn_n = 1'b0;
      at(5);
      sel = s;
      at(5);
      pdn_n = 1'b1;
      pix_word = s ? 28'h1234567 : 28'h7654321;
      wait_words(4);
      cmp_word(rx_word, s ? 28'h1234567 : 28'h7654321);
   endtask
   task automatic t_three();
      three = 1'b1;
      at(10);
      cmp_word(WORD_W'({lane_oe, lane_p[3], lane_n[3]}), 28'h000001C);
      three = 1'b0;
      at(10);
      cmp_bit(lane_oe === 4'hF, 1'b1);
   endtask
   task automatic t_shutdown();
      pix_word = 28'h2468ACE;
      wait_words(2);
      pdn_n = 1'b0;
      at(5);
      cmp_word(WORD_W'(outs), '0);
      pix_word = 28'h13579BD;
      at(40);
      pdn_n = 1'b1;
      wait_words(1);
      cmp_word(rx_word, 28'h13579BD);
   endtask
   task automatic t_idle();
      pix_run = 1'b0;
      at(230);
      cmp_word(WORD_W'(outs), '0);
      pix_run = 1'b1;
      wait_words(2);
      cmp_bit(lane_oe === 4'hF, 1'b1);
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      at(10);
      cmp_word(WORD_W'(outs), '0);
      rst_n = 1'b1;
      t_stream();
      t_edge(1'b1);
      t_edge(1'b0);
      t_three();
      t_shutdown();
      t_idle();
      cmp_bit(rx_err, 1'b0);
      print_verdict();
   end
endmodule
